/* File: core/lpt_consts.vh */
// constants of the lcd panel timing generator: register byte addresses,
// field positions, reset values and enable/disable command bits.
// assumes the full 32-bit axi address reaches the block undecoded.
`ifndef LPT_CONSTS_VH
`define LPT_CONSTS_VH

// register byte addresses
`define LPT_ADDR_CLK_CFG 32'hf8038000
`define LPT_ADDR_SYNC_PULSE_WIDTHS 32'hf8038004
`define LPT_ADDR_VERTICAL_PORCHES 32'hf8038008
`define LPT_ADDR_HORIZONTAL_PORCHES 32'hf803800c
`define LPT_ADDR_ACTIVE_AREA_SIZE 32'hf8038010
`define LPT_ADDR_OUTPUT_SIGNAL_CONFIG 32'hf8038014
`define LPT_ADDR_CONTRAST_PWM_CONFIG 32'hf8038018
`define LPT_ADDR_UNIT_ENABLE 32'hf8038020
`define LPT_ADDR_UNIT_DISABLE 32'hf8038024
`define LPT_ADDR_UNIT_STATUS 32'hf8038028

// reset value of every read/write register
`define LPT_CFG_RESET 32'h00000000

// clock configuration fields
`define LPT_PIXCLK_EDGE_SELECT 0
`define LPT_PIXCLK_SOURCE_SELECT 2
`define LPT_PWM_SOURCE_SELECT 3
`define LPT_PIXCLK_DIVIDER 23:16

// sync widths, porches, active area
`define LPT_HSYNC_WIDTH 5:0
`define LPT_VSYNC_WIDTH 21:16
`define LPT_VERT_FRONT_PORCH 5:0
`define LPT_VERT_BACK_PORCH 21:16
`define LPT_HORIZ_FRONT_PORCH 7:0
`define LPT_HORIZ_BACK_PORCH 23:16
`define LPT_PIXELS_PER_LINE 10:0
`define LPT_ROWS_PER_FRAME 26:16

// output signal configuration fields
`define LPT_HSYNC_POLARITY 0
`define LPT_VSYNC_POLARITY 1
`define LPT_VSYNC_START_ALIGN 2
`define LPT_VSYNC_END_ALIGN 3
`define LPT_PANEL_POWER_POLARITY 4
`define LPT_ENABLE_A 6
`define LPT_PANEL_POWER_SYNC 7
`define LPT_OUT_MODE 9:8
`define LPT_VSYNC_SETUP 12
`define LPT_VSYNC_HOLD 13
`define LPT_POWER_GUARD_FRAMES 20:16

// output modes
`define LPT_OUT_WIDTH_12 2'h0
`define LPT_OUT_WIDTH_16 2'h1
`define LPT_OUT_WIDTH_18 2'h2
`define LPT_OUT_WIDTH_24 2'h3

// contrast pwm fields
`define LPT_PWM_PRESCALE 2:0
`define LPT_PWM_PRESCALE_MAX 3'h6
`define LPT_PWM_POLARITY 4
`define LPT_PWM_COMPARE 15:8

// enable / disable / status bits
`define LPT_PIXCLK_ON 0
`define LPT_SYNC_ON 1
`define LPT_PANEL_POWER_ON 2
`define LPT_PWM_ON 3
`define LPT_SYNC_RESTART 9

`endif

/* File: core/lpt_timing_gen.v */
// lcd panel timing generator: pixel clock divider, sync/porch timing engine,
// panel power sequencing with guard frames, enable_a and width, contrast pwm.
// assumes an axi4-lite master on aclk and pixel data from logic on aclk.
`timescale 1ns/1ps
`include "lpt_consts.vh"

module lpt_timing_gen (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pixel source on aclk
  input wire [23:0] pixel_in,
  output wire pixel_take,
  // panel pins
  output reg pixclk_out,
  output reg hsync_out,
  output reg vsync_out,
  output reg data_enable_out,
  output reg [23:0] pixel_out,
  output reg panel_power_out,
  output reg contrast_pwm_out
);

  // software registers
  reg [31:0] clk_cfg_r;
  reg [31:0] sync_pulse_widths_r;
  reg [31:0] vertical_porches_r;
  reg [31:0] horizontal_porches_r;
  reg [31:0] active_area_size_r;
  reg [31:0] output_signal_config_r;
  reg [31:0] contrast_pwm_config_r;
  // unit run state
  reg pixclk_run_r;
  reg sync_run_r;
  reg sync_stop_req_r;
  reg pwm_run_r;
  reg power_req_r;

  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // address decode, shared by the write and read paths
  function mapped;
    input [31:0] a;
    begin
      mapped = (a == `LPT_ADDR_CLK_CFG) || (a == `LPT_ADDR_SYNC_PULSE_WIDTHS) ||
               (a == `LPT_ADDR_VERTICAL_PORCHES) || (a == `LPT_ADDR_HORIZONTAL_PORCHES) ||
               (a == `LPT_ADDR_ACTIVE_AREA_SIZE) || (a == `LPT_ADDR_OUTPUT_SIGNAL_CONFIG) ||
               (a == `LPT_ADDR_CONTRAST_PWM_CONFIG) || (a == `LPT_ADDR_UNIT_ENABLE) ||
               (a == `LPT_ADDR_UNIT_DISABLE) || (a == `LPT_ADDR_UNIT_STATUS);
    end
  endfunction

  // address and data are taken together once both are offered
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;

  // command strobes; enable acts only on ones in the low byte, disable on any strobed byte (restart is bit 9)
  wire wr_en_reg = wr_take && (s_axi_awaddr == `LPT_ADDR_UNIT_ENABLE) && s_axi_wstrb[0];
  wire wr_dis_reg = wr_take && (s_axi_awaddr == `LPT_ADDR_UNIT_DISABLE);
  wire [31:0] en_bits = wr_en_reg ? s_axi_wdata : 32'h00000000;
  wire [31:0] dis_bits = wr_dis_reg ? merge(32'h00000000, s_axi_wdata, s_axi_wstrb)
                                    : 32'h00000000;

  // field views
  wire [7:0] pixclk_divider = clk_cfg_r[`LPT_PIXCLK_DIVIDER];
  wire pixclk_edge_select = clk_cfg_r[`LPT_PIXCLK_EDGE_SELECT];
  wire [12:0] hsync_width = {7'h00, sync_pulse_widths_r[`LPT_HSYNC_WIDTH]};
  wire [12:0] vsync_width = {7'h00, sync_pulse_widths_r[`LPT_VSYNC_WIDTH]};
  wire [12:0] vert_front_porch = {7'h00, vertical_porches_r[`LPT_VERT_FRONT_PORCH]};
  wire [12:0] vert_back_porch = {7'h00, vertical_porches_r[`LPT_VERT_BACK_PORCH]};
  wire [12:0] horiz_front_porch = {5'h00, horizontal_porches_r[`LPT_HORIZ_FRONT_PORCH]};
  wire [12:0] horiz_back_porch = {5'h00, horizontal_porches_r[`LPT_HORIZ_BACK_PORCH]};
  wire [12:0] pixels_per_line = {2'h0, active_area_size_r[`LPT_PIXELS_PER_LINE]};
  wire [12:0] rows_per_frame = {2'h0, active_area_size_r[`LPT_ROWS_PER_FRAME]};
  wire [31:0] osc = output_signal_config_r;
  wire [4:0] power_guard_frames = osc[`LPT_POWER_GUARD_FRAMES];
  wire [2:0] pwm_prescale_raw = contrast_pwm_config_r[`LPT_PWM_PRESCALE];
  wire pwm_polarity = contrast_pwm_config_r[`LPT_PWM_POLARITY];
  wire [7:0] pwm_compare = contrast_pwm_config_r[`LPT_PWM_COMPARE];

  // register writes and unit enables
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg_r <= `LPT_CFG_RESET;
      sync_pulse_widths_r <= `LPT_CFG_RESET;
      vertical_porches_r <= `LPT_CFG_RESET;
      horizontal_porches_r <= `LPT_CFG_RESET;
      active_area_size_r <= `LPT_CFG_RESET;
      output_signal_config_r <= `LPT_CFG_RESET;
      contrast_pwm_config_r <= `LPT_CFG_RESET;
      pixclk_run_r <= 1'b0;
      pwm_run_r <= 1'b0;
      power_req_r <= 1'b0;
    end else begin
      if (wr_take) begin
        case (s_axi_awaddr)
          `LPT_ADDR_CLK_CFG: clk_cfg_r <= merge(clk_cfg_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_SYNC_PULSE_WIDTHS:
            sync_pulse_widths_r <= merge(sync_pulse_widths_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_VERTICAL_PORCHES:
            vertical_porches_r <= merge(vertical_porches_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_HORIZONTAL_PORCHES:
            horizontal_porches_r <= merge(horizontal_porches_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_ACTIVE_AREA_SIZE:
            active_area_size_r <= merge(active_area_size_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_OUTPUT_SIGNAL_CONFIG:
            output_signal_config_r <= merge(output_signal_config_r, s_axi_wdata, s_axi_wstrb);
          `LPT_ADDR_CONTRAST_PWM_CONFIG:
            contrast_pwm_config_r <= merge(contrast_pwm_config_r, s_axi_wdata, s_axi_wstrb);
          default: ;
        endcase
      end
      // an enable one wins over a disable in the same write burst order
      if (en_bits[`LPT_PIXCLK_ON]) begin
        pixclk_run_r <= 1'b1;
      end else if (dis_bits[`LPT_PIXCLK_ON]) begin
        pixclk_run_r <= 1'b0;
      end
      if (en_bits[`LPT_PWM_ON]) begin
        pwm_run_r <= 1'b1;
      end else if (dis_bits[`LPT_PWM_ON]) begin
        pwm_run_r <= 1'b0;
      end
      if (en_bits[`LPT_PANEL_POWER_ON]) begin
        power_req_r <= 1'b1;
      end else if (dis_bits[`LPT_PANEL_POWER_ON]) begin
        power_req_r <= 1'b0;
      end
    end
  end

  // pixel clock divider: period is divider plus two aclk cycles
  reg [8:0] div_cnt_r;
  wire [8:0] div_last = {1'b0, pixclk_divider} + 9'h001;
  wire [8:0] div_half = ({1'b0, pixclk_divider} + 9'h002) >> 1;
  wire rise_tick = pixclk_run_r && (div_cnt_r == div_last);
  wire fall_tick = pixclk_run_r && (div_cnt_r == div_half - 9'h001);
  // launch edge chosen by the edge select bit
  wire launch = pixclk_edge_select ? fall_tick : rise_tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 9'h000;
      pixclk_out <= 1'b0;
    end else if (!pixclk_run_r) begin
      div_cnt_r <= 9'h000;
      pixclk_out <= 1'b0;
    end else begin
      div_cnt_r <= rise_tick ? 9'h000 : div_cnt_r + 9'h001;
      if (rise_tick) begin
        pixclk_out <= 1'b1;
      end else if (fall_tick) begin
        pixclk_out <= 1'b0;
      end
    end
  end

  // line and frame geometry
  wire [12:0] h_bp_start = hsync_width + 13'h0001;
  wire [12:0] h_act_start = h_bp_start + horiz_back_porch + 13'h0001;
  wire [12:0] h_fp_start = h_act_start + pixels_per_line + 13'h0001;
  wire [12:0] h_last = h_fp_start + horiz_front_porch;
  wire [12:0] v_bp_start = vsync_width + 13'h0001;
  wire [12:0] v_act_start = v_bp_start + vert_back_porch;
  wire [12:0] v_fp_start = v_act_start + rows_per_frame + 13'h0001;
  wire [12:0] v_last = v_fp_start + vert_front_porch;

  reg [12:0] hpos_r;
  reg [12:0] vpos_r;
  // at-or-past compare: a geometry shrunk mid-frame cannot run the counters away
  wire line_end = (hpos_r >= h_last);
  wire frame_end = line_end && (vpos_r >= v_last);
  wire timing_adv = launch && sync_run_r;

  // engine counters; a stop request is honoured only at the end of a frame
  always @(posedge aclk) begin
    if (!aresetn) begin
      hpos_r <= 13'h0000;
      vpos_r <= 13'h0000;
      sync_run_r <= 1'b0;
      sync_stop_req_r <= 1'b0;
    end else begin
      if (en_bits[`LPT_SYNC_ON]) begin
        sync_run_r <= 1'b1;
        sync_stop_req_r <= 1'b0;
      end else if (dis_bits[`LPT_SYNC_ON]) begin
        sync_stop_req_r <= sync_run_r;
      end else if (timing_adv && frame_end && sync_stop_req_r) begin
        sync_run_r <= 1'b0;
        sync_stop_req_r <= 1'b0;
      end
      if (!sync_run_r || dis_bits[`LPT_SYNC_RESTART]) begin
        hpos_r <= 13'h0000;
        vpos_r <= 13'h0000;
      end else if (timing_adv) begin
        hpos_r <= line_end ? 13'h0000 : hpos_r + 13'h0001;
        if (line_end) begin
          vpos_r <= frame_end ? 13'h0000 : vpos_r + 13'h0001;
        end
      end
    end
  end

  // vsync window: start/end points on the line, shifted by setup and hold
  wire [12:0] vs_start_pt = osc[`LPT_VSYNC_START_ALIGN] ? 13'h0000 : h_bp_start;
  wire [12:0] vs_end_pt = osc[`LPT_VSYNC_END_ALIGN] ? 13'h0000 : h_bp_start;
  wire vs_setup = osc[`LPT_VSYNC_SETUP];
  wire [12:0] vs_s = (vs_setup && vs_start_pt != 13'h0000) ? vs_start_pt - 13'h0001
                                                          : vs_start_pt;
  wire [12:0] vs_e = vs_end_pt + {12'h000, osc[`LPT_VSYNC_HOLD]};
  // setup wraps to the last pixel of the previous frame when aligned to line start
  wire vs_wrap = vs_setup && (vs_start_pt == 13'h0000) && frame_end;
  wire vs_raw = ((vpos_r < v_bp_start) && (vpos_r != 13'h0000 || hpos_r >= vs_s)) ||
                ((vpos_r == v_bp_start) && (hpos_r < vs_e)) || vs_wrap;
  wire hs_raw = (hpos_r <= hsync_width);
  wire de_raw = (hpos_r >= h_act_start) && (hpos_r < h_fp_start) &&
                (vpos_r >= v_act_start) && (vpos_r < v_fp_start);
  // a pixel is pulled from the source in the cycle it is launched
  assign pixel_take = timing_adv && de_raw;

  // 2x2 ordered threshold, scaled into the bits the output mode drops
  wire [1:0] dith_idx = {vpos_r[0], hpos_r[0]};
  wire [1:0] bayer = {dith_idx[0] ^ dith_idx[1], dith_idx[1]};
  function [7:0] reduce;
    input [7:0] c;
    input [3:0] keep;
    input [1:0] thr;
    input dith_on;
    reg [8:0] sum;
    reg [7:0] mask;
    begin
      sum = {1'b0, c};
      mask = 8'hff << (4'h8 - keep);
      if (dith_on && keep < 4'h8) begin
        sum = sum + ((({7'h00, thr}) << (4'h8 - keep)) >> 2);
      end
      if (sum[8]) begin
        sum = 9'h0ff; // saturate so white never wraps to black
      end
      reduce = sum[7:0] & mask;
    end
  endfunction

  // bits kept per channel for each output mode, red-green-blue
  reg [3:0] keep_r_ch;
  reg [3:0] keep_g_ch;
  reg [3:0] keep_b_ch;
  always @* begin
    case (osc[`LPT_OUT_MODE])
      `LPT_OUT_WIDTH_12: begin
        keep_r_ch = 4'h4;
        keep_g_ch = 4'h4;
        keep_b_ch = 4'h4;
      end
      `LPT_OUT_WIDTH_16: begin
        keep_r_ch = 4'h5;
        keep_g_ch = 4'h6;
        keep_b_ch = 4'h5;
      end
      `LPT_OUT_WIDTH_18: begin
        keep_r_ch = 4'h6;
        keep_g_ch = 4'h6;
        keep_b_ch = 4'h6;
      end
      default: begin
        keep_r_ch = 4'h8;
        keep_g_ch = 4'h8;
        keep_b_ch = 4'h8;
      end
    endcase
  end

  // power sequencing states
  localparam PW_OFF = 2'h0;
  localparam PW_WAIT_ON = 2'h1;
  localparam PW_ON = 2'h2;
  localparam PW_WAIT_OFF = 2'h3;
  reg [1:0] pw_state_r;
  reg [4:0] guard_cnt_r;
  wire frame_done = timing_adv && frame_end;
  // second hsync edge is taken at the launch of the pulse's last pixel, one launch before the pulse ends
  wire hs_second_edge = timing_adv && (hpos_r == hsync_width);
  wire power_ok = osc[`LPT_PANEL_POWER_SYNC] || hs_second_edge;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pw_state_r <= PW_OFF;
      guard_cnt_r <= 5'h00;
    end else begin
      case (pw_state_r)
        PW_OFF: begin
          guard_cnt_r <= 5'h00;
          if (power_req_r) begin
            pw_state_r <= PW_WAIT_ON;
          end
        end
        PW_WAIT_ON: begin
          if (!power_req_r) begin
            pw_state_r <= PW_OFF;
          end else if (guard_cnt_r >= power_guard_frames && sync_run_r && power_ok) begin
            pw_state_r <= PW_ON;
          end else if (frame_done && guard_cnt_r < power_guard_frames) begin
            guard_cnt_r <= guard_cnt_r + 5'h01;
          end
        end
        PW_ON: begin
          guard_cnt_r <= 5'h00;
          if (!power_req_r) begin
            pw_state_r <= PW_WAIT_OFF;
          end
        end
        default: begin
          // guard frames after removal; a stopped engine cannot count them
          if (guard_cnt_r >= power_guard_frames || !sync_run_r) begin
            pw_state_r <= PW_OFF;
          end else if (frame_done) begin
            guard_cnt_r <= guard_cnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  // sync, enable and pixel outputs launched on the selected pixel clock edge; panel power updated every aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      data_enable_out <= 1'b0;
      pixel_out <= 24'h000000;
      panel_power_out <= 1'b0;
    end else begin
      panel_power_out <= (pw_state_r == PW_ON) ^ osc[`LPT_PANEL_POWER_POLARITY];
      if (!sync_run_r) begin
        hsync_out <= osc[`LPT_HSYNC_POLARITY];
        vsync_out <= osc[`LPT_VSYNC_POLARITY];
        data_enable_out <= 1'b0;
      end else if (launch) begin
        hsync_out <= hs_raw ^ osc[`LPT_HSYNC_POLARITY];
        vsync_out <= vs_raw ^ osc[`LPT_VSYNC_POLARITY];
        data_enable_out <= de_raw;
        if (de_raw) begin
          pixel_out <= {reduce(pixel_in[23:16], keep_r_ch, bayer, osc[`LPT_ENABLE_A]),
                        reduce(pixel_in[15:8], keep_g_ch, bayer, osc[`LPT_ENABLE_A]),
                        reduce(pixel_in[7:0], keep_b_ch, bayer, osc[`LPT_ENABLE_A])};
        end else begin
          pixel_out <= 24'h000000;
        end
      end
    end
  end

  // contrast pwm: free prescaler, 8-bit wrapping counter
  reg [5:0] pre_cnt_r;
  reg [7:0] pwm_cnt_r;
  wire [2:0] pwm_prescale = (pwm_prescale_raw > `LPT_PWM_PRESCALE_MAX) ?
                            `LPT_PWM_PRESCALE_MAX : pwm_prescale_raw;
  wire [5:0] pre_mask = ~(6'h3f << pwm_prescale);
  wire pwm_step = ((pre_cnt_r & pre_mask) == pre_mask);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= 6'h00;
      pwm_cnt_r <= 8'h00;
      contrast_pwm_out <= 1'b0;
    end else if (!pwm_run_r) begin
      pre_cnt_r <= 6'h00;
      pwm_cnt_r <= 8'h00;
      contrast_pwm_out <= !pwm_polarity; // idle at the inactive level
    end else begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
      if (pwm_step) begin
        pwm_cnt_r <= pwm_cnt_r + 8'h01;
      end
      contrast_pwm_out <= (pwm_cnt_r < pwm_compare) ~^ pwm_polarity;
    end
  end

  // status view of the running units
  wire [31:0] status_word = {27'h0000000, 1'b0, pwm_run_r, (pw_state_r == PW_ON),
                             sync_run_r, pixclk_run_r};

  // write response: okay for mapped addresses, slverr otherwise
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(s_axi_awaddr) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data; write-only registers read as zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `LPT_ADDR_CLK_CFG: s_axi_rdata <= clk_cfg_r;
        `LPT_ADDR_SYNC_PULSE_WIDTHS: s_axi_rdata <= sync_pulse_widths_r;
        `LPT_ADDR_VERTICAL_PORCHES: s_axi_rdata <= vertical_porches_r;
        `LPT_ADDR_HORIZONTAL_PORCHES: s_axi_rdata <= horizontal_porches_r;
        `LPT_ADDR_ACTIVE_AREA_SIZE: s_axi_rdata <= active_area_size_r;
        `LPT_ADDR_OUTPUT_SIGNAL_CONFIG: s_axi_rdata <= output_signal_config_r;
        `LPT_ADDR_CONTRAST_PWM_CONFIG: s_axi_rdata <= contrast_pwm_config_r;
        `LPT_ADDR_UNIT_STATUS: s_axi_rdata <= status_word;
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // lpt_timing_gen

/* File: dv/lpt_chk_properties.sv */
// assertions on the timing generator ports: bus handshakes and pixel launch
// assumes it is bound into lpt_timing_gen and sees only that module's ports
`timescale 1ns/1ps
module lpt_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid, s_axi_wvalid, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  // panel side
  input wire logic pixel_take, pixclk_out, data_enable_out,
  input wire logic [23:0] pixel_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both channels are taken together, never while a response waits
  a_wr_ready_tie: assert property (s_axi_awready |->
    s_axi_wready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) else $error("bad ready");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response stuck");
  // a taken pixel must show as active on the next edge
  a_take_enable: assert property (pixel_take |=> data_enable_out) else $error("no enable");
  a_rise_de: assert property ($rose(data_enable_out) |-> $past(pixel_take))
    else $error("enable without take");
  a_blank_black: assert property (!data_enable_out |-> pixel_out == 24'h000000)
    else $error("pixel outside active");
  // data may only move together with a pixel clock edge
  a_launch_edge: assert property (
    $changed({data_enable_out, pixel_out}) |-> $changed(pixclk_out))
    else $error("launch off clock edge");
endmodule // lpt_chk
bind lpt_timing_gen lpt_chk u_chk (.*);

/* File: dv/lpt_panel_mon.sv */
// passive panel receiver: measures sync width, active runs and frame shape
// assumes data launched on the rising pixel clock edge, sampled on the falling
`timescale 1ns/1ps
module lpt_panel_mon (
  // panel pins
  input wire logic pixclk_out, hsync_out, vsync_out, data_enable_out,
  // active level of both syncs, measured shape
  input wire logic act_lvl,
  output int hs_w, de_w, line_len, rows, frame_lines
);
  int hc = 0, dc = 0, lc = 0, rc = 0, fc = 0;
  logic hp = 0, vp = 0, dp = 0;
  // sample mid-pixel as the glass does; a stopped clock freezes all counts
  always @(negedge pixclk_out) begin
    if (vsync_out == act_lvl && !vp) begin rows = rc; frame_lines = fc; rc = 0; fc = 0; end
    if (hsync_out == act_lvl) begin
      if (!hp) begin line_len = lc; lc = 0; fc++; end
      hc++;
    end else if (hp) begin hs_w = hc; hc = 0; end
    if (data_enable_out) dc++; else if (dp) begin de_w = dc; dc = 0; rc++; end
    lc++;
    hp = hsync_out == act_lvl;
    vp = vsync_out == act_lvl;
    dp = data_enable_out;
  end
endmodule // lpt_panel_mon

/* File: dv/lpt_timing_gen_tb_top.sv */
// self-checking bench: random timing and pwm compare, all four output modes in turn, against an integer model
// assumes lpt_timing_gen, lpt_panel_mon and the bound checker are compiled
`timescale 1ns/1ps
`include "lpt_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module lpt_timing_gen_tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, act_lvl = 0, pix_on = 0, pv = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, seed = 32'h85dafc7d;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [23:0] pixel_in = 0, mask = 0, pend = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pixel_take;
  wire pixclk_out, hsync_out, vsync_out, data_enable_out, panel_power_out, contrast_pwm_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] pixel_out;
  int num_errors = 0, n_compared = 0, hs_w, de_w, line_len, rows, frame_lines;
  int f[8], w[7], i, k, n, lw, fl, cnt;
  lpt_timing_gen dut (.*);
  lpt_panel_mon pm (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task complete_run;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one write, bready held from the start until the answer
  task wr(input [31:0] a, input [31:0] d, input [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, e)
  endtask
  task rd(input [31:0] a, input [31:0] d, input [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 0;
    `CHK(s_axi_rdata, d)
    `CHK(s_axi_rresp, e)
  endtask
  initial forever #50 aclk = ~aclk;
  // hang guard, well above the longest expected run
  initial begin #(100 * 90000); num_errors++; complete_run; end
  // random pixels in; each taken pixel must come out masked one edge later
  always @(posedge aclk) begin
    pixel_in <= rnd();
    if (pv) `CHK(pixel_out, pend)
    pv <= pix_on && pixel_take === 1'b1;
    pend <= pixel_in & mask;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    for (k = 0; k < 7; k++) rd(`LPT_ADDR_CLK_CFG + 4 * k, 0, 0);
    rd(32'hf803801c, 0, 2'b10);
    wr(32'hf803801c, 32'hffffffff, 2'b10);
    for (i = 0; i < 4; i++) begin
      pix_on <= 0;
      for (k = 0; k < 8; k++) f[k] = rnd() % 4;
      w[0] = (rnd() % 3) << 16;
      w[1] = f[1] << 16 | f[0];
      w[2] = f[3] << 16 | f[2];
      w[3] = f[5] << 16 | f[4];
      w[4] = f[7] << 16 | f[6];
      w[5] = i << 16 | i << 8 | (i % 2) * 19 | (i / 3) << 6;
      w[6] = (rnd() % 256) << 8 | (i % 2) << 4 | i;
      for (k = 0; k < 7; k++) begin wr(`LPT_ADDR_CLK_CFG + 4 * k, w[k], 0); rd(`LPT_ADDR_CLK_CFG + 4 * k, w[k], 0); end
      wr(`LPT_ADDR_UNIT_ENABLE, 32'hf, 0);
      rd(`LPT_ADDR_UNIT_ENABLE, 0, 0);
      // polarity bit set means active low for syncs and power
      act_lvl <= !(i % 2);
      mask <= i == 0 ? 24'hf0f0f0 : i == 1 ? 24'hf8fcf8 : i == 2 ? 24'hfcfcfc : 24'hffffff;
      lw = f[0] + f[5] + f[6] + f[4] + 4;
      fl = f[1] + f[3] + f[7] + f[2] + 3;
      n = (w[0] / 65536 + 2) * lw * fl;
      repeat (n) @(posedge aclk);
      pix_on <= 1;
      repeat (2 * n) @(posedge aclk);
      `CHK(hs_w, f[0] + 1)
      `CHK(de_w, f[6] + 1)
      `CHK(line_len, lw)
      `CHK(rows, f[7] + 1)
      `CHK(frame_lines, fl)
      `CHK(panel_power_out, act_lvl)
      @(posedge pixclk_out) lw = int'($time);
      @(posedge pixclk_out) `CHK((int'($time) - lw) / 100, w[0] / 65536 + 2)
      repeat (2100) @(posedge aclk);
      cnt = 0;
      // pwm pulses are high for polarity 1, the opposite of the sync active level
      repeat (256 << i) @(posedge aclk) cnt += (contrast_pwm_out === ~act_lvl);
      `CHK(cnt, (w[6] >> 8) << i)
    end
    // sync stop waits for the frame end, then syncs rest inactive
    wr(`LPT_ADDR_UNIT_DISABLE, 32'h2, 0);
    repeat (n + 20) @(posedge aclk);
    rd(`LPT_ADDR_UNIT_STATUS, 32'hd, 0);
    `CHK(hsync_out, ~act_lvl)
    complete_run;
  end
endmodule // lpt_timing_gen_tb_top
